/* File: include/aack_map.svh */
// Register offsets, field positions, reset values and timing constants of the auto acknowledge block.
`ifndef AACK_MAP_SVH
`define AACK_MAP_SVH
`define AACK_OFS_DLY_LO 7'h50
`define AACK_OFS_DLY_HI 7'h51
`define AACK_OFS_TMR_CTL 7'h52
`define AACK_OFS_FC_LO 7'h53
`define AACK_OFS_FC_HI 7'h54
`define AACK_OFS_AR_CTL 7'h55
`define AACK_RST_DLY_LO 8'h08
`define AACK_RST_DLY_HI 8'h07
`define AACK_RST_TMR_CTL 8'h00
`define AACK_RST_FC_LO 8'h02
`define AACK_RST_FC_HI 8'h00
`define AACK_RST_AR_CTL 8'h00
`define AACK_BIT_TMR_EN 0
`define AACK_BIT_DONE_OFF 4
`define AACK_BIT_DONE_RX 5
`define AACK_BIT_SEND 1
`define AACK_BIT_STOP 0
`define AACK_BIT_ACK_EN 4
`define AACK_BIT_AUTO_RX 6
`define AACK_BIT_CANCEL 7
`define AACK_STATUS_RX 8'h66
`define AACK_STATUS_OFF 8'h88
`define AACK_STATUS_TX 8'h99
`define AACK_CLK_MHZ 200
`define AACK_TICK_KHZ_PER_KBPS 18
`define AACK_TICK_CYC(kbps) (((`AACK_CLK_MHZ) * 1000) / ((kbps) * (`AACK_TICK_KHZ_PER_KBPS)))
`endif

/* File: include/aack_pkg.sv */
// Types shared by the auto acknowledge block.
package aack_pkg;
   typedef enum logic [1:0] {
      aack_cmd_none,
      aack_cmd_idle,
      aack_cmd_tx_on,
      aack_cmd_rx_on
   } aack_cmd_type;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } aack_byte_type;
   typedef struct packed {
      logic write;
      logic read;
      logic [6:0] addr;
      logic [7:0] wdata;
   } aack_reg_req_type;
endpackage

/* File: rtl/aack_ctrl.sv */
// Auto acknowledge delay, frame build and post transmit state control.
`timescale 1ns/1ps
`default_nettype none
`include "aack_map.svh"
module aack_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire aack_pkg::aack_reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] rate_sel,
   input wire logic rx_done,
   input wire logic rx_ack_req,
   input wire logic rx_is_ack,
   input wire logic [7:0] rx_seq,
   input wire logic tx_done,
   input wire logic tx_ack_req,
   input wire logic in_tx,
   input wire aack_pkg::aack_cmd_type radio_state_request,
   input wire logic radio_forced_idle_cmd,
   input wire logic frame_ready,
   output aack_pkg::aack_byte_type frame_byte,
   output logic frame_start,
   output logic rx_keep,
   output logic [7:0] radio_state_status
);
   import aack_pkg::*;

   typedef enum logic [2:0] {st_idle, st_rx, st_tx_prep, st_wait, st_send, st_tx} aack_state_type;
   typedef enum logic [1:0] {rs_off, rs_rx, rs_tx} aack_radio_type;

   logic [7:0] dly_lo, dly_hi, tmr_ctl, fc_lo, fc_hi, ar_ctl;
   logic [15:0] dly_cnt;
   logic [10:0] tick_cnt;
   logic tick;
   aack_state_type state;
   aack_radio_type radio;
   aack_cmd_type pend_cmd;
   logic [2:0] byte_idx;
   logic [15:0] crc;
   logic [15:0] crc_next;
   logic wr_ctl;
   logic send_req, stop_req;

   // Tick divider lengths per rate code, zero reads as 50 kbps.
   function automatic logic [10:0] tick_len(input logic [2:0] r);
      case (r)
         3'h1: tick_len = 11'(`AACK_TICK_CYC(100));
         3'h2: tick_len = 11'(`AACK_TICK_CYC(150));
         3'h3: tick_len = 11'(`AACK_TICK_CYC(200));
         3'h4: tick_len = 11'(`AACK_TICK_CYC(400));
         3'h5: tick_len = 11'(`AACK_TICK_CYC(10));
         3'h6: tick_len = 11'(`AACK_TICK_CYC(20));
         3'h7: tick_len = 11'(`AACK_TICK_CYC(40));
         default: tick_len = 11'(`AACK_TICK_CYC(50));
      endcase
   endfunction

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c;
      for (int i = 0; i < 8; i++) begin
         x = (x[0] ^ d[i]) ? ((x >> 1) ^ 16'h8408) : (x >> 1);
      end
      crc_byte = x;
   endfunction

   assign wr_ctl = reg_req.write && reg_req.addr == `AACK_OFS_AR_CTL;
   // Stop takes precedence over send when both are written.
   assign stop_req = wr_ctl && reg_req.wdata[`AACK_BIT_STOP];
   assign send_req = wr_ctl && reg_req.wdata[`AACK_BIT_SEND] && !stop_req;

   // Registers; send and stop are commands and do not stay stored.
   always_ff @(posedge clk) begin
      if (rst) begin
         dly_lo <= `AACK_RST_DLY_LO;
         dly_hi <= `AACK_RST_DLY_HI;
         tmr_ctl <= `AACK_RST_TMR_CTL;
         fc_lo <= `AACK_RST_FC_LO;
         fc_hi <= `AACK_RST_FC_HI;
         ar_ctl <= `AACK_RST_AR_CTL;
      end else if (reg_req.write) begin
         case (reg_req.addr)
            `AACK_OFS_DLY_LO: dly_lo <= reg_req.wdata;
            `AACK_OFS_DLY_HI: dly_hi <= reg_req.wdata;
            `AACK_OFS_TMR_CTL: tmr_ctl <= reg_req.wdata;
            `AACK_OFS_FC_LO: fc_lo <= reg_req.wdata;
            `AACK_OFS_FC_HI: fc_hi <= reg_req.wdata;
            `AACK_OFS_AR_CTL: ar_ctl <= {reg_req.wdata[7:2], 2'b00};
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_req.addr)
            `AACK_OFS_DLY_LO: reg_rdata <= dly_lo;
            `AACK_OFS_DLY_HI: reg_rdata <= dly_hi;
            `AACK_OFS_TMR_CTL: reg_rdata <= tmr_ctl;
            `AACK_OFS_FC_LO: reg_rdata <= fc_lo;
            `AACK_OFS_FC_HI: reg_rdata <= fc_hi;
            `AACK_OFS_AR_CTL: reg_rdata <= ar_ctl;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Divider restarts with each delay so the first tick is a full period.
   assign tick = tick_cnt == 11'h000;
   always_ff @(posedge clk) begin
      if (rst || state != st_wait || tick) begin
         tick_cnt <= tick_len(rate_sel) - 11'h001;
      end else begin
         tick_cnt <= tick_cnt - 11'h001;
      end
   end

   // Load at end of a request packet, count down per tick.
   always_ff @(posedge clk) begin
      if (rst) begin
         dly_cnt <= 16'h0000;
      end else if (state == st_tx_prep && tmr_ctl[`AACK_BIT_TMR_EN]) begin
         dly_cnt <= {dly_hi, dly_lo};
      end else if (state == st_wait && tick && dly_cnt != 16'h0000) begin
         dly_cnt <= dly_cnt - 16'h0001;
      end
   end

   // Commands issued while sending are held until the post send state settles.
   always_ff @(posedge clk) begin
      if (rst || radio_forced_idle_cmd) begin
         pend_cmd <= aack_cmd_none;
      end else if (radio_state_request != aack_cmd_none && (in_tx || state == st_tx)) begin
         pend_cmd <= radio_state_request;
      end else if (!in_tx && state != st_tx) begin
         pend_cmd <= aack_cmd_none;
      end
   end

   // Main sequencer and radio state choice.
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= st_idle;
         radio <= rs_off;
      end else if (radio_forced_idle_cmd) begin
         state <= st_idle;
         radio <= rs_off;
      end else begin
         case (state)
            st_idle, st_rx: begin
               if (rx_done && rx_ack_req && ar_ctl[`AACK_BIT_ACK_EN]) begin
                  state <= st_tx_prep;
                  radio <= rs_tx;
               end else if (stop_req && radio == rs_rx) begin
                  radio <= rs_off;
               end else if (tx_done) begin
                  if (tmr_ctl[`AACK_BIT_DONE_RX] || (tx_ack_req && ar_ctl[`AACK_BIT_AUTO_RX])) begin
                     radio <= rs_rx;
                  end else if (tmr_ctl[`AACK_BIT_DONE_OFF]) begin
                     radio <= rs_off;
                  end else if (pend_cmd != aack_cmd_none) begin
                     radio <= pend_cmd == aack_cmd_rx_on ? rs_rx : (pend_cmd == aack_cmd_tx_on ? rs_tx : rs_off);
                  end
               end else if (!in_tx && radio_state_request != aack_cmd_none) begin
                  case (radio_state_request)
                     aack_cmd_rx_on: radio <= rs_rx;
                     aack_cmd_tx_on: radio <= rs_tx;
                     default: radio <= rs_off;
                  endcase
               end
            end
            st_tx_prep: state <= st_wait;
            st_wait: begin
               if (stop_req) begin
                  state <= st_idle;
               end else if (send_req) begin
                  state <= st_send;
               end else if (tmr_ctl[`AACK_BIT_TMR_EN] && dly_cnt == 16'h0000) begin
                  state <= st_send;
               end
            end
            st_send: state <= st_tx;
            st_tx: begin
               if (frame_byte.valid && frame_ready && byte_idx == 3'h4) begin
                  state <= st_idle;
                  if (tmr_ctl[`AACK_BIT_DONE_RX]) begin
                     radio <= rs_rx;
                  end else if (tmr_ctl[`AACK_BIT_DONE_OFF]) begin
                     radio <= rs_off;
                  end else if (pend_cmd == aack_cmd_rx_on) begin
                     radio <= rs_rx;
                  end else if (pend_cmd == aack_cmd_idle) begin
                     radio <= rs_off;
                  end
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // Frame bytes: control low, control high, sequence, check low, check high.
   logic [7:0] seq;
   always_ff @(posedge clk) begin
      if (rst) begin
         seq <= 8'h00;
      end else if (rx_done && rx_ack_req) begin
         seq <= rx_seq;
      end
   end

   // The check value runs over the byte that is being handed over.
   assign crc_next = crc_byte(crc, frame_byte.data);

   always_ff @(posedge clk) begin
      if (rst || state != st_tx) begin
         byte_idx <= 3'h0;
         crc <= 16'h0000;
      end else if (frame_byte.valid && frame_ready) begin
         byte_idx <= byte_idx + 3'h1;
         if (byte_idx < 3'h3) begin
            crc <= crc_next;
         end
      end
   end

   // Byte order is low first; the serializer sends each byte LSB first.
   // A byte advances only on a real hand-over, so a stalled consumer never loses one.
   always_ff @(posedge clk) begin
      if (rst) begin
         frame_byte <= '0;
      end else if (radio_forced_idle_cmd || (state != st_send && state != st_tx)) begin
         frame_byte.valid <= 1'b0;
      end else if (state == st_send) begin
         frame_byte.valid <= 1'b1;
         frame_byte.data <= fc_lo;
      end else if (frame_byte.valid && frame_ready) begin
         frame_byte.valid <= byte_idx != 3'h4;
         case (byte_idx)
            3'h0: frame_byte.data <= fc_hi;
            3'h1: frame_byte.data <= seq;
            3'h2: frame_byte.data <= crc_next[7:0];
            default: frame_byte.data <= crc[15:8];
         endcase
      end
   end

   assign frame_start = state == st_send;
   // Received acknowledge packets are dropped while cancel is set.
   assign rx_keep = !(rx_is_ack && ar_ctl[`AACK_BIT_CANCEL]);

   // Status codes the host polls before writing again.
   always_ff @(posedge clk) begin
      if (rst) begin
         radio_state_status <= `AACK_STATUS_OFF;
      end else begin
         case (radio)
            rs_rx: radio_state_status <= `AACK_STATUS_RX;
            rs_tx: radio_state_status <= `AACK_STATUS_TX;
            default: radio_state_status <= `AACK_STATUS_OFF;
         endcase
      end
   end

   // Each check names the rule it guards; the covers mark the main paths.
   forced_idle_a: assert property (@(posedge clk) disable iff (rst)
      radio_forced_idle_cmd |=> radio == rs_off && state == st_idle) else $error("forced idle ignored");
   reset_delay_a: assert property (@(posedge clk)
      $past(rst) |-> {dly_hi, dly_lo} == 16'h0708) else $error("delay reset wrong");
   timer_gate_a: assert property (@(posedge clk) disable iff (rst)
      state == st_wait && !tmr_ctl[0] && !send_req && !stop_req && !radio_forced_idle_cmd |=> state == st_wait)
      else $error("timer fired while disabled");
   expire_send_a: assert property (@(posedge clk) disable iff (rst)
      state == st_wait && tmr_ctl[0] && dly_cnt == 16'h0000 && !stop_req && !radio_forced_idle_cmd |=> state == st_send)
      else $error("no send at expiry");
   stop_wins_a: assert property (@(posedge clk) disable iff (rst)
      state == st_wait && stop_req && !radio_forced_idle_cmd |=> state == st_idle) else $error("stop lost");
   cancel_drop_a: assert property (@(posedge clk) disable iff (rst)
      rx_is_ack && ar_ctl[7] |-> !rx_keep) else $error("ack not dropped");
   rx_status_a: assert property (@(posedge clk) disable iff (rst)
      radio == rs_rx ##1 radio == rs_rx |-> radio_state_status == 8'h66) else $error("status not 66");
   ack_enter_tx_a: assert property (@(posedge clk) disable iff (rst)
      (state == st_idle || state == st_rx) && rx_done && rx_ack_req && ar_ctl[4] && !radio_forced_idle_cmd
      |=> state == st_tx_prep ##1 state == st_wait) else $error("auto ack not started");
   done_rx_a: assert property (@(posedge clk) disable iff (rst)
      state == st_idle && tx_done && tmr_ctl[5] && !radio_forced_idle_cmd && !(rx_done && rx_ack_req && ar_ctl[4])
      |=> radio == rs_rx) else $error("post send listen missed");
   send_bit_a: assert property (@(posedge clk) disable iff (rst)
      state == st_wait && send_req && !radio_forced_idle_cmd |=> state == st_send)
      else $error("send bit ignored");
   frame_hold_a: assert property (@(posedge clk) disable iff (rst)
      frame_byte.valid && !frame_ready && !radio_forced_idle_cmd |=> $stable(frame_byte))
      else $error("frame byte changed while stalled");
   frame_done_a: assert property (@(posedge clk) disable iff (rst)
      state == st_tx && frame_byte.valid && frame_ready && byte_idx == 3'h4 && !radio_forced_idle_cmd
      |=> state == st_idle && !frame_byte.valid) else $error("frame not ended after five bytes");
   post_off_a: assert property (@(posedge clk) disable iff (rst)
      state == st_tx && frame_byte.valid && frame_ready && byte_idx == 3'h4 && tmr_ctl[4] && !tmr_ctl[5]
      && !radio_forced_idle_cmd |=> radio == rs_off) else $error("post send off missed");
   held_cmd_a: assert property (@(posedge clk) disable iff (rst)
      state == st_idle && in_tx && !tx_done && !rx_done && !stop_req && !radio_forced_idle_cmd |=> $stable(radio))
      else $error("command acted during send");
   stop_rx_a: assert property (@(posedge clk) disable iff (rst)
      state == st_idle && stop_req && radio == rs_rx && !rx_done && !radio_forced_idle_cmd |=> radio == rs_off)
      else $error("stop in receive not idle");
   off_status_a: assert property (@(posedge clk) disable iff (rst)
      radio == rs_off ##1 radio == rs_off |-> radio_state_status == 8'h88) else $error("status not 88");
   tx_status_a: assert property (@(posedge clk) disable iff (rst)
      radio == rs_tx ##1 radio == rs_tx |-> radio_state_status == 8'h99) else $error("status not 99");
   keep_default_a: assert property (@(posedge clk) disable iff (rst)
      !ar_ctl[7] |-> rx_keep) else $error("packet dropped without cancel");

   ack_sent_c: cover property (@(posedge clk) disable iff (rst) state == st_send ##[1:20] state == st_idle);
   timer_run_c: cover property (@(posedge clk) disable iff (rst) state == st_wait && tick && dly_cnt == 16'h0001);
   stop_c: cover property (@(posedge clk) disable iff (rst) state == st_wait && stop_req);
   post_rx_c: cover property (@(posedge clk) disable iff (rst) state == st_idle && tx_done && tx_ack_req && ar_ctl[6]);
   frame_stall_c: cover property (@(posedge clk) disable iff (rst) frame_byte.valid && !frame_ready);
endmodule
`default_nettype wire

/* File: sim/aack_peer.sv */
// Remote radio node model: sends acknowledge requests and takes acknowledge bytes.
`timescale 1ns/1ps
`default_nettype none
module aack_peer (
   input wire logic clk,
   input wire aack_pkg::aack_byte_type frame_byte,
   output logic rx_done,
   output logic rx_ack_req,
   output logic [7:0] rx_seq,
   output logic frame_ready
);
   import aack_pkg::*;
   logic slow = 1'b0;
   logic [7:0] got [$];
   initial begin
      rx_done = 1'b0;
      rx_ack_req = 1'b0;
      rx_seq = 8'h00;
      frame_ready = 1'b1;
   end
   // The sequence lines are inverted once released, so a stale value is never mistaken for a live one.
   task automatic send_req(input logic [7:0] s);
      @(posedge clk);
      #1 rx_done = 1'b1;
      rx_ack_req = 1'b1;
      rx_seq = s;
      @(posedge clk);
      #1 rx_done = 1'b0;
      rx_ack_req = 1'b0;
      rx_seq = ~s;
   endtask
   always @(posedge clk) begin
      if (frame_byte.valid && frame_ready) begin
         got.push_back(frame_byte.data);
      end
      #1 frame_ready = slow ? ~frame_ready : 1'b1;
   end
endmodule
`default_nettype wire

/* File: sim/auto_ack_post_tx_control_tb.sv */
// Self-checking testbench of the auto acknowledge block.
`timescale 1ns/1ps
`default_nettype none
`include "aack_map.svh"
module auto_ack_post_tx_control_tb;
   import aack_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   aack_reg_req_type reg_req = '0;
   logic [7:0] reg_rdata, rx_seq, radio_state_status;
   logic [2:0] rate_sel = 3'h1;
   logic rx_done, rx_ack_req, frame_ready, frame_start, rx_keep;
   logic rx_is_ack = 1'b0;
   logic tx_done = 1'b0;
   logic tx_ack_req = 1'b0;
   logic in_tx = 1'b0;
   aack_cmd_type radio_state_request = aack_cmd_none;
   logic radio_forced_idle_cmd = 1'b0;
   aack_byte_type frame_byte;
   int n_errors = 0;
   int samples_checked = 0;
   aack_ctrl dut (.clk, .rst, .reg_req, .reg_rdata, .rate_sel, .rx_done, .rx_ack_req, .rx_is_ack,
      .rx_seq, .tx_done, .tx_ack_req, .in_tx, .radio_state_request, .radio_forced_idle_cmd,
      .frame_ready, .frame_byte, .frame_start, .rx_keep, .radio_state_status);
   aack_peer peer (.clk, .frame_byte, .rx_done, .rx_ack_req, .rx_seq, .frame_ready);
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic results;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_req = '{1'b1, 1'b0, a, d};
      @(posedge clk);
      #1 reg_req.write = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk);
      #1 reg_req.addr = a;
      @(posedge clk);
      #1 check(reg_rdata, e, "read");
   endtask
   task automatic cmd(input aack_cmd_type c);
      @(posedge clk);
      #1 radio_state_request = c;
      @(posedge clk);
      #1 radio_state_request = aack_cmd_none;
   endtask
   // Bounded wait, so a design that never settles still ends in a compare.
   task automatic wait_status(input logic [7:0] e);
      for (int i = 0; i < 40 && radio_state_status !== e; i++) begin
         @(posedge clk);
         #1;
      end
      check(radio_state_status, e, "status");
   endtask
   task automatic wait_start(input int lim, output int n);
      for (n = 0; n < lim && frame_start !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
   endtask
   function automatic logic [15:0] crc(input logic [23:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 0; i < 24; i++) begin
         c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      end
      return c;
   endfunction
   task automatic frame_check(input logic [7:0] s, input logic [15:0] fc);
      logic [15:0] c;
      logic [7:0] e [5];
      c = crc({s, fc});
      e = '{fc[7:0], fc[15:8], s, c[7:0], c[15:8]};
      for (int i = 0; i < 300 && peer.got.size() < 5; i++) begin
         @(posedge clk);
      end
      repeat (6) @(posedge clk);
      #1;
      check(16'(peer.got.size()), 16'h0005, "frame length");
      for (int i = 0; i < 5 && i < peer.got.size(); i++) begin
         check(peer.got[i], e[i], "frame byte");
      end
      peer.got.delete();
   endtask
   task automatic t_regs;
      rd(`AACK_OFS_DLY_LO, 8'h08);
      rd(`AACK_OFS_DLY_HI, 8'h07);
      rd(`AACK_OFS_TMR_CTL, 8'h00);
      rd(`AACK_OFS_FC_LO, 8'h02);
      rd(`AACK_OFS_FC_HI, 8'h00);
      rd(`AACK_OFS_AR_CTL, 8'h00);
      rd(7'h56, 8'h00);
   endtask
   task automatic t_send;
      int n;
      wr(`AACK_OFS_FC_LO, 8'h62);
      wr(`AACK_OFS_FC_HI, 8'ha4);
      wr(`AACK_OFS_AR_CTL, 8'h10);
      peer.send_req(8'h5a);
      wait_status(8'h99);
      wait_start(300, n);
      check(16'(n), 16'd300, "sent without timer");
      wr(`AACK_OFS_AR_CTL, 8'h12);
      frame_check(8'h5a, 16'ha462);
      rd(`AACK_OFS_AR_CTL, 8'h10);
   endtask
   // Two data rates: the divider restarts with each delay, and the start time is judged within one tick.
   task automatic t_timer;
      int n;
      real tk;
      int kb [2] = '{100, 400};
      logic [2:0] rs [2] = '{3'h1, 3'h4};
      logic [7:0] cn [2] = '{8'h03, 8'h0c};
      logic [7:0] ct [2] = '{8'h31, 8'h11};
      logic [7:0] ps [2] = '{8'h66, 8'h88};
      peer.slow = 1'b1;
      for (int i = 0; i < 2; i++) begin
         rate_sel = rs[i];
         tk = 200.0 / (0.018 * kb[i]);
         wr(`AACK_OFS_DLY_LO, cn[i]);
         wr(`AACK_OFS_DLY_HI, 8'h00);
         wr(`AACK_OFS_TMR_CTL, ct[i]);
         peer.send_req(8'hc3 + 8'(i));
         wait_start(2000, n);
         check(16'(n >= int'((cn[i] - 1) * tk) && n <= int'(cn[i] * tk) + 10), 16'h1, "delay");
         frame_check(8'hc3 + 8'(i), 16'ha462);
         wait_status(ps[i]);
      end
      peer.slow = 1'b0;
   endtask
   task automatic t_stop;
      int n;
      wr(`AACK_OFS_TMR_CTL, 8'h00);
      peer.send_req(8'h11);
      wait_status(8'h99);
      wr(`AACK_OFS_AR_CTL, 8'h13);
      wait_start(300, n);
      check(16'(n), 16'd300, "stopped ack sent");
      check(radio_state_status, 8'h99, "status after stop");
      cmd(aack_cmd_rx_on);
      wait_status(8'h66);
      wr(`AACK_OFS_AR_CTL, 8'h11);
      wait_status(8'h88);
      rx_is_ack = 1'b1;
      wr(`AACK_OFS_AR_CTL, 8'h80);
      check(rx_keep, 1'b0, "keep");
      wr(`AACK_OFS_AR_CTL, 8'h00);
      check(rx_keep, 1'b1, "keep");
      rx_is_ack = 1'b0;
   endtask
   task automatic tx_end(input logic ack);
      @(posedge clk);
      #1 tx_done = 1'b1;
      tx_ack_req = ack;
      in_tx = 1'b0;
      @(posedge clk);
      #1 tx_done = 1'b0;
      tx_ack_req = 1'b0;
   endtask
   task automatic t_post;
      cmd(aack_cmd_tx_on);
      in_tx = 1'b1;
      cmd(aack_cmd_idle);
      repeat (10) @(posedge clk);
      #1;
      check(radio_state_status, 8'h99, "held command");
      tx_end(1'b0);
      wait_status(8'h88);
      wr(`AACK_OFS_AR_CTL, 8'h40);
      cmd(aack_cmd_tx_on);
      in_tx = 1'b1;
      tx_end(1'b1);
      wait_status(8'h66);
      cmd(aack_cmd_tx_on);
      in_tx = 1'b1;
      wr(`AACK_OFS_TMR_CTL, 8'h20);
      @(posedge clk);
      #1 radio_forced_idle_cmd = 1'b1;
      @(posedge clk);
      #1 radio_forced_idle_cmd = 1'b0;
      wait_status(8'h88);
      in_tx = 1'b0;
   endtask
   initial begin
      #200000;
      n_errors++;
      results();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      t_regs();
      t_send();
      t_timer();
      t_stop();
      t_post();
      results();
   end
endmodule
`default_nettype wire
